//--- rtl/pmt_defs.vh
// constants for the pmbus telemetry and limits block
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH
`define PMT_CMD_OT_FAULT 8'h4f
`define PMT_CMD_OT_WARN 8'h51
`define PMT_CMD_VIN_OV_FAULT 8'h55
`define PMT_CMD_VIN_OV_WARN 8'h57
`define PMT_CMD_IIN_OC_FAULT 8'h5b
`define PMT_CMD_IIN_OC_WARN 8'h5d
`define PMT_CMD_TON_DLY 8'h60
`define PMT_CMD_OPERATION 8'h01
`define PMT_CMD_RD_VIN 8'h88
`define PMT_CMD_RD_IIN 8'h89
`define PMT_CMD_RD_VOUT 8'h8b
`define PMT_CMD_RD_IOUT 8'h8c
`define PMT_CMD_RD_TEMP 8'h8d
`define PMT_CMD_RD_ROUT 8'hd4
`define PMT_CMD_FAULT_DIS 8'hd7
// disabled-state defaults: -300 v at 0.1 v units, -273 c
`define PMT_VOUT_DISABLED 16'hf448
`define PMT_TEMP_DISABLED 16'hfeef
// factory limits, 100 percent of protection values (tenths / hundredths / degrees)
`define PMT_DEF_OT_FAULT 16'h007d
`define PMT_DEF_OT_WARN 16'h007d
`define PMT_DEF_VIN_OV_FAULT 16'h0294
`define PMT_DEF_VIN_OV_WARN 16'h0294
// recovery 3 percent under the default fault limit, x - x*31/1024
`define PMT_DEF_OV_RECOVERY 16'h0281
`define PMT_DEF_IIN_OC_FAULT 16'h1130
`define PMT_DEF_IIN_OC_WARN 16'h1130
`define PMT_DEF_TON_DLY 16'h0000
`define PMT_TON_DLY_MAX 16'h0064
`define PMT_FAULT_DIS_PRESET 16'h0000
`define PMT_FAULT_DIS_UV 16'h0001
// timing, 100 mhz clock
`define PMT_CLK_MHZ 100
`define PMT_ROUT_PERIOD_MS 100
`define PMT_BIAS_ON_US 1500
`define PMT_MS_CYCLES 100000
`define PMT_ADDR_BASE 7'h50
`endif

//--- rtl/pmt_sync.v
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module pmt_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= d_i[g];
          s2_q <= s1_q;
        end
      end
      assign q_o[g] = s2_q;
    end
  endgenerate
endmodule

//--- rtl/pmt_core.v
// pmbus command handler: telemetry reads, gated limit writes, address strap
// Notes on behaviour
// - current readings only while forward converting; reverse reads return zero
// - resistance read d4h, value refreshed every 100 ms, units 1e-5 ohm
// - disabled converter reads low-side voltage as fixed -300 v
// - disabled converter reads temperature as fixed -273 c
// - limits start at factory values, 100 percent of protection values
// - limit writes only when disabled, input under uv, bias present
// - writing overvoltage fault limit sets recovery threshold 3 percent lower
// - fault disable only selects preset default, arbitrary values refused
// - turn-on delay 0..100 ms added after undervoltage start-up delay
// - operation and threshold writes require bias supply powered
// - telemetry readable without bias; lost when input removed without bias
// - address sampled at start-up and kept until power cycle
// - address pin 0..3.3 v decoded into 16 bands of 206.25 mv
// - smbus-compatible, no alert line; host polls status
`timescale 1ns/1ps
`include "pmt_defs.vh"
module pmt_core #(
  parameter BIAS_ON_CYC = `PMT_BIAS_ON_US * `PMT_CLK_MHZ,
  parameter ROUT_CYC = `PMT_ROUT_PERIOD_MS * `PMT_MS_CYCLES,
  parameter MS_CYC = `PMT_MS_CYCLES
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire bias_supply_input_i,
  input wire hi_side_present_i,
  input wire hi_side_below_uv_i,
  input wire forward_i,
  input wire uv_start_done_i,
  input wire [3:0] addr_band_i,
  input wire [15:0] vin_adc_i,
  input wire [15:0] iin_adc_i,
  input wire [15:0] vout_adc_i,
  input wire [15:0] iout_adc_i,
  input wire [15:0] temp_adc_i,
  input wire [15:0] rout_adc_i,
  output reg enabled_o,
  output reg powertrain_on_o,
  output reg [15:0] ov_recovery_o,
  output reg [15:0] ot_fault_o,
  output reg [15:0] ot_warn_o,
  output reg [15:0] vin_ov_fault_o,
  output reg [15:0] vin_ov_warn_o,
  output reg [15:0] iin_oc_fault_o,
  output reg [15:0] iin_oc_warn_o,
  output reg [15:0] turn_on_delay_o,
  output reg uv_fault_disabled_o,
  output reg [6:0] bus_addr_o,
  output reg bus_active_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_RD = 3'h4;
  localparam ST_RACK = 3'h5;
  localparam ST_SKIP = 3'h6;

  wire [5:0] sy;
  pmt_sync #(.W(6)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({scl_i, sda_i, bias_supply_input_i, hi_side_present_i, hi_side_below_uv_i,
      forward_i}),
    .q_o(sy)
  );
  wire scl_s = sy[5];
  wire sda_s = sy[4];
  wire bias_s = sy[3];
  wire hip_s = sy[2];
  wire uvb_s = sy[1];
  wire fwd_s = sy[0];

  reg scl_q;
  reg sda_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [1:0] byte_q;
  reg rd_q;
  reg [7:0] cmd_q;
  reg [15:0] wdat_q;
  reg [15:0] rdat_q;
  reg [15:0] rout_q;
  reg [31:0] rout_cnt_q;
  reg [31:0] on_cnt_q;
  reg [31:0] dly_cnt_q;
  reg addr_done_q;
  reg tele_valid_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire wr_ok = ~enabled_o & uvb_s & bias_s;

  // read mux
  reg [15:0] rd_val;
  always @* begin
    rd_val = 16'h0000;
    if (tele_valid_q) begin
      case (cmd_q)
        `PMT_CMD_RD_VIN: rd_val = vin_adc_i;
        `PMT_CMD_RD_IIN: rd_val = fwd_s ? iin_adc_i : 16'h0000;
        `PMT_CMD_RD_IOUT: rd_val = fwd_s ? iout_adc_i : 16'h0000;
        `PMT_CMD_RD_VOUT: rd_val = enabled_o ? vout_adc_i : `PMT_VOUT_DISABLED;
        `PMT_CMD_RD_TEMP: rd_val = enabled_o ? temp_adc_i : `PMT_TEMP_DISABLED;
        `PMT_CMD_RD_ROUT: rd_val = rout_q;
        default: rd_val = 16'h0000;
      endcase
    end
    case (cmd_q)
      `PMT_CMD_OT_FAULT: rd_val = ot_fault_o;
      `PMT_CMD_OT_WARN: rd_val = ot_warn_o;
      `PMT_CMD_VIN_OV_FAULT: rd_val = vin_ov_fault_o;
      `PMT_CMD_VIN_OV_WARN: rd_val = vin_ov_warn_o;
      `PMT_CMD_IIN_OC_FAULT: rd_val = iin_oc_fault_o;
      `PMT_CMD_IIN_OC_WARN: rd_val = iin_oc_warn_o;
      `PMT_CMD_TON_DLY: rd_val = turn_on_delay_o;
      `PMT_CMD_FAULT_DIS: rd_val = {15'h0000, uv_fault_disabled_o};
      `PMT_CMD_OPERATION: rd_val = {8'h00, enabled_o, 7'h00};
      default: rd_val = rd_val;
    endcase
  end

  // 3 percent below: x - (x*31)/1024 approximates x*0.97
  wire [15:0] ov_in = {wdat_q[7:0], wdat_q[15:8]};
  wire [20:0] ov_m = ov_in * 5'h1f;
  wire [15:0] ov_rec = ov_in - {5'h00, ov_m[20:10]};

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_q <= 2'h0;
      rd_q <= 1'b0;
      cmd_q <= 8'h00;
      wdat_q <= 16'h0000;
      rdat_q <= 16'h0000;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      enabled_o <= 1'b0;
      ot_fault_o <= `PMT_DEF_OT_FAULT;
      ot_warn_o <= `PMT_DEF_OT_WARN;
      vin_ov_fault_o <= `PMT_DEF_VIN_OV_FAULT;
      vin_ov_warn_o <= `PMT_DEF_VIN_OV_WARN;
      iin_oc_fault_o <= `PMT_DEF_IIN_OC_FAULT;
      iin_oc_warn_o <= `PMT_DEF_IIN_OC_WARN;
      turn_on_delay_o <= `PMT_DEF_TON_DLY;
      ov_recovery_o <= `PMT_DEF_OV_RECOVERY;
      uv_fault_disabled_o <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (start_c && bus_active_o) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_o <= 1'b0;
        if (!rd_q && byte_q == 2'h3 && wr_ok) begin
          case (cmd_q)
            `PMT_CMD_OT_FAULT: ot_fault_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_OT_WARN: ot_warn_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_VIN_OV_FAULT: begin
              vin_ov_fault_o <= ov_in;
              ov_recovery_o <= ov_rec;
            end
            `PMT_CMD_VIN_OV_WARN: vin_ov_warn_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_IIN_OC_FAULT: iin_oc_fault_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_IIN_OC_WARN: iin_oc_warn_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_TON_DLY: if ({wdat_q[7:0], wdat_q[15:8]} <= `PMT_TON_DLY_MAX)
              turn_on_delay_o <= {wdat_q[7:0], wdat_q[15:8]};
            `PMT_CMD_FAULT_DIS: begin
              if ({wdat_q[7:0], wdat_q[15:8]} == `PMT_FAULT_DIS_UV)
                uv_fault_disabled_o <= 1'b1;
              else if ({wdat_q[7:0], wdat_q[15:8]} == `PMT_FAULT_DIS_PRESET)
                uv_fault_disabled_o <= 1'b0;
            end
            default: ;
          endcase
        end
        if (!rd_q && byte_q == 2'h2 && cmd_q == `PMT_CMD_OPERATION && bias_s)
          enabled_o <= wdat_q[7];
      end else begin
        case (st_q)
          ST_IDLE: sda_oe_o <= 1'b0;
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] == bus_addr_o) begin
                  rd_q <= sh_q[0];
                  if (!sh_q[0])
                    byte_q <= 2'h0;
                  else
                    rdat_q <= rd_val;
                  sda_o <= 1'b0;
                  sda_oe_o <= 1'b1;
                  st_q <= ST_ACK;
                end else begin
                  st_q <= ST_SKIP;
                end
              end else begin
                if (byte_q == 2'h0)
                  cmd_q <= sh_q;
                else
                  wdat_q <= {wdat_q[7:0], sh_q};
                if (byte_q != 2'h3)
                  byte_q <= byte_q + 2'h1;
                sda_o <= 1'b0;
                sda_oe_o <= 1'b1;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_q) begin
                sda_o <= rdat_q[15];
                sda_oe_o <= ~rdat_q[15];
                rdat_q <= {rdat_q[14:0], 1'b0};
                bit_q <= 4'h1;
                st_q <= ST_RD;
              end else begin
                sda_oe_o <= 1'b0;
                st_q <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_oe_o <= 1'b0;
                st_q <= ST_RACK;
              end else begin
                sda_o <= rdat_q[15];
                sda_oe_o <= ~rdat_q[15];
                rdat_q <= {rdat_q[14:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise)
              st_q <= sda_s ? ST_SKIP : ST_ACK;
          end
          ST_SKIP: sda_oe_o <= 1'b0;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // reads go out high byte first, msb first
  // resistance snapshot, start-up and powertrain timing
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rout_q <= 16'h0000;
      rout_cnt_q <= 32'h0;
      on_cnt_q <= 32'h0;
      dly_cnt_q <= 32'h0;
      bus_active_o <= 1'b0;
      addr_done_q <= 1'b0;
      bus_addr_o <= `PMT_ADDR_BASE;
      tele_valid_q <= 1'b0;
      powertrain_on_o <= 1'b0;
    end else begin
      if (rout_cnt_q >= ROUT_CYC - 1) begin
        rout_cnt_q <= 32'h0;
        rout_q <= rout_adc_i;
      end else begin
        rout_cnt_q <= rout_cnt_q + 32'h1;
      end
      if (!bias_s) begin
        on_cnt_q <= 32'h0;
      end else if (on_cnt_q < BIAS_ON_CYC - 1) begin
        on_cnt_q <= on_cnt_q + 32'h1;
      end else begin
        bus_active_o <= 1'b1;
        if (!addr_done_q) begin
          addr_done_q <= 1'b1;
          bus_addr_o <= `PMT_ADDR_BASE | {3'h0, addr_band_i};
        end
      end
      if (hip_s)
        tele_valid_q <= 1'b1;
      else if (!bias_s)
        tele_valid_q <= 1'b0;
      if (!enabled_o || !uv_start_done_i) begin
        dly_cnt_q <= 32'h0;
        powertrain_on_o <= 1'b0;
      end else if (dly_cnt_q < turn_on_delay_o * MS_CYC) begin
        dly_cnt_q <= dly_cnt_q + 32'h1;
      end else begin
        powertrain_on_o <= 1'b1;
      end
    end
  end
endmodule

//--- bench/pmt_core_chk.sv
// concurrent checks on the pmbus command handler ports
`timescale 1ns/1ps
module pmt_core_chk #(
  parameter BIAS_ON_CYC = 150000
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire bias_supply_input_i,
  input wire hi_side_below_uv_i,
  input wire uv_start_done_i,
  input wire enabled_o,
  input wire powertrain_on_o,
  input wire [15:0] ov_recovery_o,
  input wire [15:0] ot_fault_o,
  input wire [15:0] vin_ov_fault_o,
  input wire [15:0] turn_on_delay_o,
  input wire [6:0] bus_addr_o,
  input wire bus_active_o
);
  reg [31:0] bias_cnt_q;
  wire [31:0] ov_x31 = {16'h0, vin_ov_fault_o} * 32'd31;
  wire [15:0] rec_exp = vin_ov_fault_o - ov_x31[25:10];
  // consecutive cycles with bias present
  always @(posedge ref_clk_i) begin
    if (rst_i || !bias_supply_input_i) begin
      bias_cnt_q <= 32'h0;
    end else if (bias_cnt_q != 32'hffffffff) begin
      bias_cnt_q <= bias_cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_ADDR_HOLD: assert property (bus_active_o && $past(bus_active_o) |-> $stable(bus_addr_o))
    else $error("bus address moved while active");
  AST_ADDR_BASE: assert property (bus_addr_o[6:4] == 3'h5)
    else $error("bus address outside strap range");
  AST_BUS_WAIT: assert property ($rose(bus_active_o) |-> bias_cnt_q >= BIAS_ON_CYC - 1)
    else $error("bus active too early after bias");
  AST_SDA_PULL: assert property (sda_oe_o |-> !sda_o && bus_active_o)
    else $error("data line driven high or while inactive");
  AST_WR_GATE: assert property ($changed({ot_fault_o, vin_ov_fault_o, turn_on_delay_o}) |->
    $past(!enabled_o && hi_side_below_uv_i && bias_supply_input_i))
    else $error("limit changed with write conditions unmet");
  AST_EN_BIAS: assert property ($rose(enabled_o) |-> $past(bias_supply_input_i))
    else $error("converter enabled without bias");
  AST_RECOV: assert property ($stable(vin_ov_fault_o) [*2] |-> ov_recovery_o == rec_exp)
    else $error("recovery threshold not three percent lower");
  AST_TON_MAX: assert property (turn_on_delay_o <= 16'h0064)
    else $error("turn-on delay above range");
  AST_PT_START: assert property ($rose(powertrain_on_o) |-> $past(uv_start_done_i && enabled_o))
    else $error("powertrain started before start-up delay");
endmodule
bind pmt_core pmt_core_chk #(.BIAS_ON_CYC(BIAS_ON_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .bias_supply_input_i(bias_supply_input_i), .hi_side_below_uv_i(hi_side_below_uv_i),
  .uv_start_done_i(uv_start_done_i), .enabled_o(enabled_o), .powertrain_on_o(powertrain_on_o),
  .ov_recovery_o(ov_recovery_o), .ot_fault_o(ot_fault_o), .vin_ov_fault_o(vin_ov_fault_o),
  .turn_on_delay_o(turn_on_delay_o), .bus_addr_o(bus_addr_o), .bus_active_o(bus_active_o)
);

//--- bench/pmt_host.sv
// bus host model: word writes and word reads, 80 ns serial clock
`timescale 1ns/1ps
module pmt_host (
  input wire ref_clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_oe_o
);
  reg nak;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    nak = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // data set mid-low, sampled one cycle into the high phase
  task bit_io(input b, output r);
    begin
      tick(2);
      sda_oe_o <= !b;
      tick(2);
      scl_o <= 1'b1;
      tick(1);
      r = sda_i;
      tick(3);
      scl_o <= 1'b0;
    end
  endtask
  task start;
    begin
      tick(2);
      sda_oe_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      sda_oe_o <= 1'b1;
      tick(2);
      scl_o <= 1'b0;
    end
  endtask
  task stop;
    begin
      tick(2);
      sda_oe_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      sda_oe_o <= 1'b0;
      tick(4);
    end
  endtask
  task send(input [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      nak = nak | r;
    end
  endtask
  task recv(input last, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, r);
        d[i] = r;
      end
      bit_io(last, r);
    end
  endtask
  // status is polled, no alert line exists
  task wr(input [6:0] a, input [7:0] c, input [15:0] v);
    begin
      nak = 1'b0;
      start;
      send({a, 1'b0});
      send(c);
      send(v[7:0]);
      send(v[15:8]);
      stop;
    end
  endtask
  task wrb(input [6:0] a, input [7:0] c, input [7:0] v);
    begin
      nak = 1'b0;
      start;
      send({a, 1'b0});
      send(c);
      send(v);
      stop;
    end
  endtask
  task rd(input [6:0] a, input [7:0] c, output [15:0] v);
    begin
      nak = 1'b0;
      start;
      send({a, 1'b0});
      send(c);
      start;
      send({a, 1'b1});
      recv(1'b0, v[15:8]);
      recv(1'b1, v[7:0]);
      stop;
    end
  endtask
endmodule

//--- bench/tb_top.sv
// testbench for the pmbus command handler
`timescale 1ns/1ps
module tb_top;
  localparam MS = 10;
  localparam [47:0] CMDS = 48'h88898b8c8dd4;
  reg ref_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg bias = 1'b1;
  reg below_uv = 1'b1;
  reg fwd = 1'b1;
  reg hip = 1'b1;
  reg uv_done = 1'b0;
  reg [3:0] band = 4'h5;
  reg [15:0] adcv [0:5];
  wire scl, h_oe, d_o, d_oe, en, pt, uvd, act;
  wire [15:0] rec, otf, ovf, ton, otw, ovw, ocf, ocw;
  wire [6:0] addr;
  wire sda = !(h_oe | (d_oe & !d_o));
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer k;
  reg [15:0] v;
  always #5 ref_clk_i = !ref_clk_i;
  initial for (k = 0; k < 6; k = k + 1) adcv[k] = {8'ha5, CMDS[47-8*k -: 8]};
  pmt_host i_host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
  pmt_core #(.BIAS_ON_CYC(15), .ROUT_CYC(100), .MS_CYC(MS)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
    .sda_oe_o(d_oe), .bias_supply_input_i(bias), .hi_side_present_i(hip),
    .hi_side_below_uv_i(below_uv), .forward_i(fwd), .uv_start_done_i(uv_done),
    .addr_band_i(band), .vin_adc_i(adcv[0]), .iin_adc_i(adcv[1]), .vout_adc_i(adcv[2]),
    .iout_adc_i(adcv[3]), .temp_adc_i(adcv[4]), .rout_adc_i(adcv[5]), .enabled_o(en),
    .powertrain_on_o(pt), .ov_recovery_o(rec), .ot_fault_o(otf), .vin_ov_fault_o(ovf),
    .iin_oc_fault_o(ocf), .ot_warn_o(otw), .vin_ov_warn_o(ovw), .iin_oc_warn_o(ocw),
    .turn_on_delay_o(ton), .uv_fault_disabled_o(uvd), .bus_addr_o(addr), .bus_active_o(act));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // word write, check the ack, then wait 3 * MS cycles for the commit
  task w(input [7:0] c, input [15:0] val);
    begin
      i_host.wr(7'h55, c, val);
      chk("ack", 16'h0, {15'h0, i_host.nak});
      repeat (3 * MS) @(posedge ref_clk_i);
    end
  endtask
  // one-byte operation write, enable in bit 7
  task wb(input [7:0] val);
    begin
      i_host.wrb(7'h55, 8'h01, val);
      chk("ack", 16'h0, {15'h0, i_host.nak});
      repeat (3 * MS) @(posedge ref_clk_i);
    end
  endtask
  task r(input [7:0] c, input [15:0] e, input string nm);
    begin
      i_host.rd(7'h55, c, v);
      chk(nm, e, v);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 200 && act !== 1'b1; k = k + 1) @(posedge ref_clk_i);
    chk("bus_active", 16'h1, {15'h0, act});
    band <= 4'ha;
    repeat (5) @(posedge ref_clk_i);
    chk("bus_addr", 16'h55, {9'h0, addr});
    chk("ot_fault", 16'h007d, otf);
    chk("vin_ov_fault", 16'h0294, ovf);
    chk("turn_on_delay", 16'h0000, ton);
    chk("ot_warn", 16'h007d, otw);
    chk("vin_ov_warn", 16'h0294, ovw);
    chk("iin_oc_fault", 16'h1130, ocf);
    chk("iin_oc_warn", 16'h1130, ocw);
    chk("ov_recovery default", 16'h0281, rec);
    i_host.wr(7'h56, 8'h55, 16'h0123);
    chk("foreign addr nak", 16'h1, {15'h0, i_host.nak});
    w(8'h55, 16'h0280);
    chk("vin_ov_fault", 16'h0280, ovf);
    chk("ov_recovery", 16'd640 - 16'd640 * 16'd31 / 16'd1024, rec);
    r(8'h55, 16'h0280, "ov readback");
    below_uv <= 1'b0;
    w(8'h4f, 16'h0050);
    chk("ot_fault refused", 16'h007d, otf);
    below_uv <= 1'b1;
    w(8'h60, 16'h0065);
    chk("ton over range", 16'h0000, ton);
    w(8'h60, 16'h0003);
    chk("ton", 16'h0003, ton);
    w(8'h51, 16'h0064);
    chk("ot_warn", 16'h0064, otw);
    w(8'h57, 16'h0280);
    chk("vin_ov_warn", 16'h0280, ovw);
    w(8'h5b, 16'h1000);
    chk("iin_oc_fault", 16'h1000, ocf);
    w(8'h5d, 16'h0f00);
    chk("iin_oc_warn", 16'h0f00, ocw);
    bias <= 1'b0;
    w(8'h51, 16'h0010);
    chk("ot_warn no bias", 16'h0064, otw);
    wb(8'h80);
    chk("enable no bias", 16'h0, {15'h0, en});
    bias <= 1'b1;
    w(8'hd7, 16'h0002);
    chk("uv arbitrary", 16'h0, {15'h0, uvd});
    w(8'hd7, 16'h0001);
    chk("uv preset", 16'h1, {15'h0, uvd});
    w(8'hd7, 16'h0000);
    chk("uv restore", 16'h0, {15'h0, uvd});
    r(8'h8b, 16'hf448, "vout disabled");
    r(8'h8d, 16'hfeef, "temp disabled");
    wb(8'h80);
    chk("enabled", 16'h1, {15'h0, en});
    uv_done <= 1'b1;
    repeat (2 * MS) @(posedge ref_clk_i);
    chk("powertrain early", 16'h0, {15'h0, pt});
    repeat (2 * MS) @(posedge ref_clk_i);
    chk("powertrain", 16'h1, {15'h0, pt});
    w(8'h4f, 16'h0050);
    chk("ot_fault enabled", 16'h007d, otf);
    for (k = 0; k < 6; k = k + 1) r(CMDS[47-8*k -: 8], adcv[k], "telemetry");
    fwd <= 1'b0;
    r(8'h89, 16'h0000, "iin reverse");
    r(8'h8c, 16'h0000, "iout reverse");
    bias <= 1'b0;
    r(8'h88, adcv[0], "vin no bias");
    hip <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    r(8'h88, 16'h0000, "vin lost");
    finish_test;
  end
endmodule
